// ==== src/slc_cmd_filter.v ====
// Command decoder for servo-loop configuration and identity address filter.
// Assumes a word stream from a serial front end on clk, with a start flag on
// the first word of each command (the address word precedes the opcode word).
`include "slc_consts.vh"

module slc_cmd_filter (
    // Clock and reset
    input  wire        clk,
    input  wire        rst_b,
    // Command word stream
    input  wire        word_valid,
    input  wire        word_first,
    input  wire [15:0] word_data,
    // Configuration
    input  wire        respond_group,
    input  wire        dual_loop_set,
    input  wire        basic_filter_load,
    // Loop state
    output reg         closed_loop_q,
    output reg         phase_req_q,
    output reg         dual_loop_mode_q,
    output reg         observer_model_q,
    output reg         second_accel_en_q,
    // Stored values
    output reg  [15:0] gravity_offset_q,
    output reg  [7:0]  unit_id_q,
    output reg  [7:0]  group_id_q,
    // Parameter readback
    input  wire [2:0]  param_sel,
    output wire [15:0] param_data_q,
    // Acknowledge
    output reg         ack_q,
    output reg  [7:0]  ack_unit_q,
    output reg         cmd_accept_q
);
    // ==================================================
    // Framing states, one-hot encoded
    localparam ST_IDLE   = 3'b001;
    localparam ST_OPCODE = 3'b010;
    localparam ST_PARAM  = 3'b100;

    reg  [2:0]  state_q;
    reg  [7:0]  opcode_q;
    reg  [2:0]  word_cnt_q;
    reg  [2:0]  len_q;
    reg         accepted_q;
    reg         answer_q;
    wire        mem_wr;
    wire [2:0]  mem_addr;

    // Length of a known command; zero marks an opcode outside this block
    function [2:0] cmd_len;
        input [7:0] op;
        begin
            case (op)
                `SLC_OP_OBSERVER_FILTER: cmd_len = `SLC_LEN_OBSERVER;
                `SLC_OP_GRAVITY_OFFSET:  cmd_len = `SLC_LEN_GRAVITY;
                `SLC_OP_IDENTITY:        cmd_len = `SLC_LEN_IDENTITY;
                `SLC_OP_CLOSED_LOOP_DC,
                `SLC_OP_CLOSED_PHASED,
                `SLC_OP_OPEN_LOOP:       cmd_len = `SLC_LEN_SINGLE;
                default:                 cmd_len = 3'd0;
            endcase
        end
    endfunction

    // ==================================================
    // Address match: unit answers, group only with respond_group, global never answers
    wire [7:0] addr      = word_data[7:0];
    wire       hit_unit  = (addr == unit_id_q);
    wire       hit_group = (group_id_q != `SLC_GROUP_DISABLED) &&
                           (addr == group_id_q);
    wire       hit_glob  = (addr == `SLC_ADDR_GLOBAL);
    wire       hit_any   = hit_unit || hit_group || hit_glob;
    wire       answers   = hit_unit || (hit_group && respond_group);

    wire       last_word = (word_cnt_q == len_q - 3'd1);
    wire       param_w   = word_valid && !word_first && (state_q == ST_PARAM);

    assign mem_wr   = param_w && (opcode_q == `SLC_OP_OBSERVER_FILTER);
    assign mem_addr = word_cnt_q - 3'd1;

    // ==================================================
    // Parameter store
    slc_param_mem u_mem (
        .clk       (clk),
        .rst_b     (rst_b),
        .wr_en     (mem_wr),
        .wr_addr   (mem_addr),
        .wr_data   (word_data),
        .rd_addr   (param_sel),
        .rd_data_q (param_data_q)
    );

    // ==================================================
    // Framing
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q    <= ST_IDLE;
            opcode_q   <= 8'h00;
            word_cnt_q <= 3'd0;
            len_q      <= 3'd0;
            accepted_q <= 1'b0;
            answer_q   <= 1'b0;
        end else if (word_valid && word_first) begin
            // A new first word always restarts framing, dropping any partial command
            state_q    <= hit_any ? ST_OPCODE : ST_IDLE;
            accepted_q <= hit_any;
            answer_q   <= answers;
            word_cnt_q <= 3'd0;
        end else if (word_valid) begin
            case (state_q)
                ST_OPCODE: begin
                    opcode_q   <= word_data[7:0];
                    len_q      <= cmd_len(word_data[7:0]);
                    word_cnt_q <= 3'd1;
                    state_q    <= (cmd_len(word_data[7:0]) > `SLC_LEN_SINGLE) ?
                                  ST_PARAM : ST_IDLE;
                end
                ST_PARAM: begin
                    word_cnt_q <= word_cnt_q + 3'd1;
                    if (last_word) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Execute strobe: completion of a known, accepted command
    wire op_single = word_valid && !word_first && (state_q == ST_OPCODE) &&
                     (cmd_len(word_data[7:0]) == `SLC_LEN_SINGLE);
    wire op_multi  = param_w && last_word;
    wire exec      = accepted_q && (op_single || op_multi);
    wire [7:0] eop = op_single ? word_data[7:0] : opcode_q;

    // ==================================================
    // Execution
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            closed_loop_q     <= 1'b0;
            phase_req_q       <= 1'b0;
            dual_loop_mode_q  <= 1'b0;
            observer_model_q  <= 1'b0;
            second_accel_en_q <= 1'b0;
            gravity_offset_q  <= `SLC_GRAV_RST;
            unit_id_q         <= `SLC_UNIT_RST;
            group_id_q        <= `SLC_GROUP_RST;
            ack_q             <= 1'b0;
            ack_unit_q        <= `SLC_UNIT_RST;
            cmd_accept_q      <= 1'b0;
        end else begin
            ack_q        <= exec && answer_q;
            cmd_accept_q <= exec;
            phase_req_q  <= exec && (eop == `SLC_OP_CLOSED_PHASED);
            if (basic_filter_load) begin
                observer_model_q  <= 1'b0;
                second_accel_en_q <= 1'b0;
            end
            // Dual loop needs the position loop closed; an open-loop command wins
            if (dual_loop_set && closed_loop_q) begin
                dual_loop_mode_q <= 1'b1;
            end
            if (exec) begin
                ack_unit_q <= unit_id_q;
                case (eop)
                    `SLC_OP_OBSERVER_FILTER: begin
                        observer_model_q  <= 1'b1;
                        second_accel_en_q <= 1'b1;
                    end
                    `SLC_OP_CLOSED_LOOP_DC: closed_loop_q <= 1'b1;
                    `SLC_OP_CLOSED_PHASED:  closed_loop_q <= 1'b1;
                    `SLC_OP_OPEN_LOOP: begin
                        closed_loop_q    <= 1'b0;
                        dual_loop_mode_q <= 1'b0;
                    end
                    `SLC_OP_GRAVITY_OFFSET: begin
                        // -32768 is out of range and is clamped to the minimum
                        gravity_offset_q <= (word_data == 16'h8000) ?
                                            `SLC_GRAV_MIN : word_data;
                    end
                    `SLC_OP_IDENTITY: begin
                        group_id_q <= word_data[`SLC_ID_GROUP_MSB:`SLC_ID_GROUP_LSB];
                        unit_id_q  <= word_data[`SLC_ID_UNIT_MSB:`SLC_ID_UNIT_LSB];
                        ack_unit_q <= word_data[`SLC_ID_UNIT_MSB:`SLC_ID_UNIT_LSB];
                    end
                    default: begin
                        closed_loop_q <= closed_loop_q;
                    end
                endcase
            end
        end
    end
endmodule // slc_cmd_filter

// ==== include/slc_consts.vh ====
// Constants for the servo-loop command and identity filter block.
// Assumes inclusion by bare name from src files; definitions only.
`ifndef SLC_CONSTS_VH
`define SLC_CONSTS_VH

// ==================================================
// Opcodes
`define SLC_OP_OBSERVER_FILTER 8'h44
`define SLC_OP_CLOSED_LOOP_DC  8'h58
`define SLC_OP_CLOSED_PHASED   8'h8e
`define SLC_OP_GRAVITY_OFFSET  8'hed
`define SLC_OP_OPEN_LOOP       8'h8f
`define SLC_OP_IDENTITY        8'h9b

// ==================================================
// Command lengths in words, opcode word included
`define SLC_LEN_OBSERVER       3'd7
`define SLC_LEN_GRAVITY        3'd2
`define SLC_LEN_IDENTITY       3'd2
`define SLC_LEN_SINGLE         3'd1
`define SLC_OBS_PARAMS         6

// ==================================================
// Addressing and reset values
`define SLC_ADDR_GLOBAL        8'hff
`define SLC_GROUP_DISABLED     8'h00
`define SLC_UNIT_RST           8'h10
`define SLC_GROUP_RST          8'h14
`define SLC_GRAV_RST           16'h0000
`define SLC_GRAV_MIN           16'h8001
`define SLC_ID_GROUP_MSB       15
`define SLC_ID_GROUP_LSB       8
`define SLC_ID_UNIT_MSB        7
`define SLC_ID_UNIT_LSB        0

`endif

// ==== src/slc_param_mem.v ====
// Small memory holding the six observer filter parameter words.
// Assumes one clock; read data are registered, one cycle latency.
module slc_param_mem (
    // Clock and reset
    input  wire        clk,
    input  wire        rst_b,
    // Write port
    input  wire        wr_en,
    input  wire [2:0]  wr_addr,
    input  wire [15:0] wr_data,
    // Read port
    input  wire [2:0]  rd_addr,
    output reg  [15:0] rd_data_q
);
    reg [15:0] mem_q [0:7];

    always @(posedge clk) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data_q <= 16'h0000;
        end else begin
            rd_data_q <= mem_q[rd_addr];
        end
    end
endmodule // slc_param_mem

// ==== verification/slc_cmd_filter_sva.sv ====
// Assertions on the command filter ports.
// Assumes one clock and an asynchronous active-low reset.
module slc_cmd_filter_sva (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        closed_loop_q,
    input wire logic        phase_req_q,
    input wire logic        dual_loop_mode_q,
    input wire logic        observer_model_q,
    input wire logic        second_accel_en_q,
    input wire logic [15:0] gravity_offset_q,
    input wire logic [7:0]  unit_id_q,
    input wire logic        ack_q,
    input wire logic [7:0]  ack_unit_q,
    input wire logic        cmd_accept_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ==================================================
    // Properties
    property p_ack_acc; ack_q |-> cmd_accept_q; endproperty
    a_ack_acc: assert property (p_ack_acc) else $error("ack without accept");
    property p_ack_unit; ack_q |-> ack_unit_q == unit_id_q; endproperty
    a_ack_unit: assert property (p_ack_unit) else $error("ack unit wrong");
    property p_phase; phase_req_q |-> closed_loop_q && cmd_accept_q; endproperty
    a_phase: assert property (p_phase) else $error("phasing outside closed entry");
    property p_dual; $fell(closed_loop_q) |-> !dual_loop_mode_q; endproperty
    a_dual: assert property (p_dual) else $error("dual loop kept in open loop");
    property p_close; $rose(closed_loop_q) |-> cmd_accept_q; endproperty
    a_close: assert property (p_close) else $error("closed loop without command");
    property p_obs; $rose(observer_model_q) |-> cmd_accept_q && second_accel_en_q; endproperty
    a_obs: assert property (p_obs) else $error("observer flags wrong");
    property p_grav; !$stable(gravity_offset_q) |-> cmd_accept_q && gravity_offset_q != 16'h8000;
    endproperty
    a_grav: assert property (p_grav) else $error("offset changed wrongly");
    property p_once; cmd_accept_q |=> !cmd_accept_q && !ack_q; endproperty
    a_once: assert property (p_once) else $error("accept pulse too long");
endmodule // slc_cmd_filter_sva

bind slc_cmd_filter slc_cmd_filter_sva u_slc_cmd_filter_sva (.clk, .rst_b, .closed_loop_q,
    .phase_req_q, .dual_loop_mode_q, .observer_model_q, .second_accel_en_q, .gravity_offset_q,
    .unit_id_q, .ack_q, .ack_unit_q, .cmd_accept_q);

// ==== verification/slc_host_model.sv ====
// Host on the command network, sending whole commands as words.
// Assumes words are taken at rising clk; drives at falling edge.
module slc_host_model (
    input  wire logic  clk,
    output logic       word_valid,
    output logic       word_first,
    output logic [15:0] word_data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        word_valid = 1'b0;
        word_first = 1'b0;
        word_data  = 16'h0000;
    end
    task automatic put(input logic f, input logic [15:0] d);
        @(negedge clk);
        word_valid = 1'b1;
        word_first = f;
        word_data  = d;
    endtask
    // Caller keeps identities in 1..254 and unit apart from group
    task automatic send(input logic [7:0] a, op, input int n, input logic [95:0] prm);
        put(1'b1, {8'h00, a});
        put(1'b0, {8'h00, op});
        for (int i = 0; i < n; i++) put(1'b0, prm[16*i +: 16]);
        @(negedge clk);
        word_valid = 1'b0;
        word_first = 1'b0;
        // Released line shows a changing pattern, not the last word
        word_data  = ~word_data;
    endtask
endmodule // slc_host_model

// ==== verification/slc_cmd_filter_test.sv ====
// Self-checking bench for the command filter with a host model.
// Assumes the filter and its parameter memory are compiled alongside.
module slc_cmd_filter_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_b = 0, respond_group = 0, dual_loop_set = 0, basic_filter_load = 0;
    logic [2:0] param_sel = 3'h0;
    logic word_valid, word_first, closed_loop_q, phase_req_q, dual_loop_mode_q;
    logic observer_model_q, second_accel_en_q, ack_q, cmd_accept_q;
    logic [15:0] word_data, gravity_offset_q, param_data_q, g;
    logic [7:0] unit_id_q, group_id_q, ack_unit_q;
    logic [95:0] prm;
    logic [9:0] notes[$];
    logic [9:0] n;
    int fail_count = 0, tests_run = 0, seed = 96815;
    always #4 clk = ~clk;
    slc_host_model u_slc_host_model (.clk, .word_valid, .word_first, .word_data);
    slc_cmd_filter u_slc_cmd_filter (.clk, .rst_b, .word_valid, .word_first, .word_data,
        .respond_group, .dual_loop_set, .basic_filter_load, .closed_loop_q, .phase_req_q,
        .dual_loop_mode_q, .observer_model_q, .second_accel_en_q, .gravity_offset_q,
        .unit_id_q, .group_id_q, .param_sel, .param_data_q, .ack_q, .ack_unit_q, .cmd_accept_q);
    // ==================================================
    // Checking
    task automatic check(input logic [15:0] got, exp, input string what);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Pulses are read mid-cycle, away from the edge that launches them
    always @(negedge clk) if (cmd_accept_q === 1'b1) begin
        if (notes.size() == 0) check(16'h1, 16'h0, "unexpected accept");
        else begin
            n = notes.pop_front();
            check(ack_q, n[8], "ack");
            check(phase_req_q, n[9], "phase");
            if (n[8]) check(ack_unit_q, n[7:0], "ack unit");
        end
    end
    // ==================================================
    // Stimulus
    task automatic run(input logic [7:0] a, op, input int k, input logic acc, ak,
                       input logic [7:0] u, input string name);
        if (acc) notes.push_back({op == 8'h8e, ak, u});
        u_slc_host_model.send(a, op, k, prm);
        repeat (2) @(negedge clk);
        $display("Done: %s", name);
    endtask
    task automatic pulse(input bit dual);
        @(negedge clk);
        if (dual) dual_loop_set = 1'b1;
        else basic_filter_load = 1'b1;
        @(negedge clk);
        dual_loop_set = 1'b0;
        basic_filter_load = 1'b0;
    endtask
    initial begin
        #100us;
        fail_count++;
        give_verdict;
    end
    initial begin
        prm = 96'h0;
        repeat (20) @(posedge clk);
        @(negedge clk) rst_b = 1'b1;
        check({unit_id_q, group_id_q}, 16'h1014, "reset ids");
        check(gravity_offset_q, 16'h0000, "reset offset");
        check(closed_loop_q, 1'b0, "reset loop");
        run(8'h10, 8'h8f, 0, 1, 1, 8'h10, "open loop unit");
        run(8'h10, 8'h58, 0, 1, 1, 8'h10, "closed dc");
        check(closed_loop_q, 1'b1, "closed dc");
        pulse(1'b1);
        check(dual_loop_mode_q, 1'b1, "dual set");
        run(8'hff, 8'h8f, 0, 1, 0, 8'h10, "open loop global");
        check({closed_loop_q, dual_loop_mode_q}, 2'b00, "open clears dual");
        run(8'h10, 8'h8e, 0, 1, 1, 8'h10, "closed phased");
        check(closed_loop_q, 1'b1, "closed phased");
        for (int i = 0; i < 3; i++) begin
            g = (i == 0) ? 16'h8000 : 16'($random(seed));
            prm = {80'h0, g};
            if (g == 16'h8000) g = 16'h8001;
            respond_group = (i == 2);
            run(i == 0 ? 8'h10 : 8'h14, 8'hed, 1, 1, i != 1, 8'h10, "offset");
            check(gravity_offset_q, g, "offset");
        end
        respond_group = 1'b0;
        prm = {$random(seed), $random(seed), $random(seed)};
        run(8'h10, 8'h44, 6, 1, 1, 8'h10, "observer");
        check({observer_model_q, second_accel_en_q}, 2'b11, "observer flags");
        for (int i = 0; i < 6; i++) begin
            param_sel = i[2:0];
            repeat (2) @(negedge clk);
            check(param_data_q, prm[16*i +: 16], "param");
        end
        pulse(1'b0);
        check({observer_model_q, second_accel_en_q}, 2'b00, "basic filter");
        prm = {80'h0, 16'h0021};
        run(8'h10, 8'h9b, 1, 1, 1, 8'h21, "identity");
        check({unit_id_q, group_id_q}, 16'h2100, "new ids");
        run(8'h14, 8'h58, 0, 0, 0, 8'h00, "old group");
        run(8'h00, 8'h58, 0, 0, 0, 8'h00, "zero group");
        run(8'h21, 8'h58, 0, 1, 1, 8'h21, "new unit");
        check(notes.size(), 16'h0, "pending acks");
        give_verdict;
    end
endmodule // slc_cmd_filter_test
